// ### src/wdt_consts.svh
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// register byte addresses
`define WDT_CTRL_OFS 16'h1100
`define WDT_SVC_OFS 16'h1104
`define WDT_STAT_OFS 16'h1108

// control field positions and reset value
`define WDT_TSEL_HI 3
`define WDT_TSEL_LO 2
`define WDT_CLKS_BIT 1
`define WDT_WIN_BIT 0
`define WDT_CTRL_W 4
`define WDT_CTRL_RESET 4'h0

// service keys
`define WDT_SVC_KEY1 8'h55
`define WDT_SVC_KEY2 8'haa

// timeout exponents: low-power clock and bus clock
`define WDT_LP_EXP1 5'h05
`define WDT_LP_EXP2 5'h08
`define WDT_LP_EXP3 5'h0a
`define WDT_BUS_EXP1 5'h0d
`define WDT_BUS_EXP2 5'h10
`define WDT_BUS_EXP3 5'h12

// status field positions
`define WDT_ST_WIN 0
`define WDT_ST_REQ 1
`define WDT_ST_FAULT 2
`define WDT_ST_ARMED 3
`define WDT_ST_LOCK 4
`define WDT_ST_CNT_LO 8

// timing
`define WDT_CLK_PERIOD_NS 4
`define WDT_LPO_PERIOD_NS 1000000
`define WDT_LPO_CYCLES (`WDT_LPO_PERIOD_NS / `WDT_CLK_PERIOD_NS)

`endif

// ### src/wdt_pkg.sv
`default_nettype none

package wdt_pkg;

    typedef enum logic [1:0] {
        WDT_SVC_IDLE  = 2'b01,
        WDT_SVC_ARMED = 2'b10
    } wdt_svc_state_t;

    typedef enum logic [1:0] {
        WDT_TSEL_OFF   = 2'b00,
        WDT_TSEL_SHORT = 2'b01,
        WDT_TSEL_MID   = 2'b10,
        WDT_TSEL_LONG  = 2'b11
    } wdt_tsel_t;

endpackage

`default_nettype wire

// ### src/wdt_top.sv
`include "wdt_consts.svh"
`default_nettype none

// How it works
// R01 - control register takes only its first write after reset; later writes ignored
// R02 - timeout select 00 disables the watchdog; no timeout can occur
// R03 - select 01/10/11 give 2^5/2^8/2^10 slow or 2^13/2^16/2^18 bus cycles
// R04 - clock select 0 counts the 1 kHz low-power clock, 1 counts bus clock
// R05 - window enable 1 selects windowed mode, effective only with bus clock
// R06 - in windowed mode the service window opens at three quarters of timeout
// R07 - software restarts the counter by writing 0x55 then 0xaa to service
// R08 - control bits 31 to 4 read as zero and ignore writes
// R09 - enabled counter reaching timeout without service raises a reset request
// R10 - windowed service completed before the window opens raises the reset request
module wdt_top #(
    parameter int LPO_DIV = `WDT_LPO_CYCLES,
    parameter int AW = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic reset_req_o,
    output logic window_open_o
);

    function automatic logic [18:0] limit_f(input logic [1:0] sel, input logic bus);
        logic [4:0] e;
        e = 5'h00;
        case (sel)
            2'b01: e = bus ? `WDT_BUS_EXP1 : `WDT_LP_EXP1;
            2'b10: e = bus ? `WDT_BUS_EXP2 : `WDT_LP_EXP2;
            2'b11: e = bus ? `WDT_BUS_EXP3 : `WDT_LP_EXP3;
            default: e = 5'h00;
        endcase
        limit_f = 19'h00001 << e;
    endfunction

    logic [`WDT_CTRL_W-1:0] ctrl;
    logic locked;
    logic [18:0] count;
    logic [17:0] lpo_div;
    logic fault_cause;
    wdt_pkg::wdt_svc_state_t svc_state;
    wdt_pkg::wdt_svc_state_t next_svc_state;

    // address decode
    wire sel_ctrl = (addr_i == `WDT_CTRL_OFS);
    wire sel_svc = (addr_i == `WDT_SVC_OFS);
    wire sel_stat = (addr_i == `WDT_STAT_OFS);
    wire ctrl_wr = wr_i && sel_ctrl;
    wire svc_wr = wr_i && sel_svc;
    wire key1 = svc_wr && (wdata_i[7:0] == `WDT_SVC_KEY1);
    wire key2 = svc_wr && (wdata_i[7:0] == `WDT_SVC_KEY2);

    // configuration fields
    wire [1:0] tsel = ctrl[`WDT_TSEL_HI:`WDT_TSEL_LO];
    wire clk_bus = ctrl[`WDT_CLKS_BIT];
    wire enabled = (tsel != wdt_pkg::WDT_TSEL_OFF); // R02
    wire win_mode = ctrl[`WDT_WIN_BIT] && clk_bus; // R05
    wire [18:0] limit = limit_f(tsel, clk_bus); // R03
    wire [18:0] win_thr = limit - (limit >> 2); // R06
    wire window_now = win_mode && (count >= win_thr);

    // counting clock: bus clock or divided low-power rate
    wire lpo_tick = (lpo_div == 18'(LPO_DIV - 1));
    wire cnt_tick = clk_bus ? 1'b1 : lpo_tick;

    wire svc_done = key2 && (svc_state == wdt_pkg::WDT_SVC_ARMED);
    wire early = svc_done && win_mode && !window_now;
    wire svc_ok = svc_done && !early;
    wire timeout = enabled && !reset_req_o && cnt_tick && !svc_ok &&
        (count == limit - 19'h00001);
    wire fault = enabled && !reset_req_o && early;

    wire [18:0] next_count =
        (!enabled || reset_req_o) ? 19'h00000 :
        svc_ok ? 19'h00000 :
        cnt_tick ? count + 19'h00001 : count;
    wire next_req = reset_req_o || timeout || fault;

    wire [31:0] stat_val = {5'h00, count, 3'h0, locked,
        svc_state == wdt_pkg::WDT_SVC_ARMED, fault_cause, reset_req_o, window_now};
    wire [31:0] next_rdata =
        !rd_i ? 32'h00000000 :
        sel_ctrl ? {28'h0000000, ctrl} :
        sel_stat ? stat_val : 32'h00000000;

    // service key sequence
    always_comb begin
        next_svc_state = svc_state;
        case (svc_state)
            wdt_pkg::WDT_SVC_IDLE: begin
                if (key1) begin
                    next_svc_state = wdt_pkg::WDT_SVC_ARMED;
                end
            end
            wdt_pkg::WDT_SVC_ARMED: begin
                if (svc_wr && !key1) begin
                    next_svc_state = wdt_pkg::WDT_SVC_IDLE;
                end
            end
            default: next_svc_state = wdt_pkg::WDT_SVC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= `WDT_CTRL_RESET;
            locked <= 1'b0;
        end else if (ctrl_wr && !locked) begin
            ctrl <= wdata_i[`WDT_CTRL_W-1:0]; // R01 R08
            locked <= 1'b1; // R01
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lpo_div <= 18'h00000;
        end else begin
            lpo_div <= lpo_tick ? 18'h00000 : lpo_div + 18'h00001; // R04
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            svc_state <= wdt_pkg::WDT_SVC_IDLE;
            count <= 19'h00000;
            reset_req_o <= 1'b0;
            fault_cause <= 1'b0;
        end else begin
            svc_state <= next_svc_state; // R07
            count <= next_count; // R02 R04 R07
            reset_req_o <= next_req; // R09 R10
            if (fault) begin
                fault_cause <= 1'b1; // R10
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 32'h00000000;
            window_open_o <= 1'b0;
        end else begin
            rdata_o <= next_rdata; // R08
            window_open_o <= window_now; // R06
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_LOCK_HOLD: assert property ( // R01
        locked |=> $stable(ctrl) && locked
    ) else $error("control changed after first write");

    AST_FIRST_WRITE: assert property ( // R01
        ctrl_wr && !locked |=> ctrl == $past(wdata_i[3:0])
    ) else $error("first control write not stored");

    AST_OFF_NO_REQ: assert property ( // R02
        !enabled && !reset_req_o |=> !reset_req_o && count == 19'h00000
    ) else $error("disabled watchdog counted or requested reset");

    AST_LIMIT_VAL: assert property ( // R03
        (tsel == 2'b01 && clk_bus) |-> limit == 19'h02000
    ) else $error("short bus timeout length wrong");

    AST_LIMIT_LPO: assert property ( // R03
        (tsel == 2'b11 && !clk_bus) |-> limit == 19'h00400
    ) else $error("long slow timeout length wrong");

    AST_LPO_STEP: assert property ( // R04
        enabled && !clk_bus && !lpo_tick && !svc_ok && !reset_req_o |=> $stable(count)
    ) else $error("counter moved without low-power tick");

    AST_WIN_BUS_ONLY: assert property ( // R05
        !clk_bus |-> !window_now
    ) else $error("window open on low-power clock");

    AST_WIN_OPEN: assert property ( // R06
        win_mode && count >= limit - (limit >> 2) |=> window_open_o
    ) else $error("window did not open at three quarters");

    AST_SVC_CLEAR: assert property ( // R07
        svc_ok && enabled && !reset_req_o |=> count == 19'h00000
    ) else $error("service sequence did not restart counter");

    AST_RSV_ZERO: assert property ( // R08
        rd_i && sel_ctrl |=> rdata_o[31:4] == 28'h0000000
    ) else $error("reserved control bits not zero");

    AST_TIMEOUT_REQ: assert property ( // R09
        enabled && cnt_tick && count == limit - 19'h00001 && !svc_ok |=> reset_req_o
    ) else $error("timeout did not raise reset request");

    AST_EARLY_FAULT: assert property ( // R10
        enabled && !reset_req_o && svc_done && win_mode && !window_now |=>
        reset_req_o && fault_cause
    ) else $error("early windowed service not faulted");

    AST_LOCK_SET: assert property ( // R01
        ctrl_wr |=> locked
    ) else $error("control write did not lock");

    AST_UNLOCKED_RESET: assert property ( // R01
        !locked |-> ctrl == `WDT_CTRL_RESET
    ) else $error("unlocked control not at reset value");

    AST_OFF_NO_TIMEOUT: assert property ( // R02
        !enabled |-> !timeout && !fault
    ) else $error("disabled watchdog raised a cause");

    AST_OFF_NO_FAULT: assert property ( // R02
        !enabled && !fault_cause |=> !fault_cause
    ) else $error("disabled watchdog recorded a fault");

    AST_LIMIT_LPO_SHORT: assert property ( // R03
        (tsel == 2'b01 && !clk_bus) |-> limit == 19'h00020
    ) else $error("short slow timeout length wrong");

    AST_LIMIT_LPO_MID: assert property ( // R03
        (tsel == 2'b10 && !clk_bus) |-> limit == 19'h00100
    ) else $error("middle slow timeout length wrong");

    AST_LIMIT_BUS_MID: assert property ( // R03
        (tsel == 2'b10 && clk_bus) |-> limit == 19'h10000
    ) else $error("middle bus timeout length wrong");

    AST_LIMIT_BUS_LONG: assert property ( // R03
        (tsel == 2'b11 && clk_bus) |-> limit == 19'h40000
    ) else $error("long bus timeout length wrong");

    AST_COUNT_STEP: assert property ( // R03
        enabled && cnt_tick && !svc_ok && !reset_req_o &&
        count != limit - 19'h00001 |=> count == $past(count) + 19'h00001
    ) else $error("counter did not step on a tick");

    AST_BUS_EVERY_CYCLE: assert property ( // R04
        enabled && clk_bus && !svc_ok && !reset_req_o && count < limit - 19'h00001 |=>
        count == $past(count) + 19'h00001
    ) else $error("bus clock counter skipped a cycle");

    AST_LPO_WRAP: assert property ( // R04
        lpo_tick |=> lpo_div == 18'h00000
    ) else $error("low-power divider did not wrap");

    AST_NORMAL_NO_WIN: assert property ( // R05
        !ctrl[`WDT_WIN_BIT] |-> !window_now
    ) else $error("window open in normal mode");

    AST_WIN_SHUT: assert property ( // R06
        win_mode && tsel == 2'b01 && count < 19'h01800 |-> !window_now
    ) else $error("window open before three quarters");

    AST_WIN_FOLLOW: assert property ( // R06
        !window_now |=> !window_open_o
    ) else $error("window output open while window shut");

    AST_SVC_IN_WINDOW: assert property ( // R06
        svc_ok && !reset_req_o |=> !reset_req_o
    ) else $error("timely service raised reset request");

    AST_KEY1_ARMS: assert property ( // R07
        key1 |=> svc_state == wdt_pkg::WDT_SVC_ARMED
    ) else $error("first key did not arm");

    AST_OTHER_DISARMS: assert property ( // R07
        svc_wr && !key1 |=> svc_state == wdt_pkg::WDT_SVC_IDLE
    ) else $error("service write did not disarm");

    AST_KEY2_IDLE: assert property ( // R07
        key2 && svc_state == wdt_pkg::WDT_SVC_IDLE && enabled && !reset_req_o && clk_bus &&
        count < limit - 19'h00001 |=> count != 19'h00000
    ) else $error("second key alone restarted counter");

    AST_RDATA_ONE_CYCLE: assert property ( // R08
        !rd_i |=> rdata_o == 32'h00000000
    ) else $error("read data stood without a read");

    AST_UNMAPPED_ZERO: assert property ( // R08
        rd_i && !sel_ctrl && !sel_stat |=> rdata_o == 32'h00000000
    ) else $error("unmapped read not zero");

    AST_REQ_STICKY: assert property ( // R09
        reset_req_o |=> reset_req_o
    ) else $error("reset request dropped before reset");

    AST_REQ_HOLDS_COUNT: assert property ( // R09
        reset_req_o |=> count == 19'h00000
    ) else $error("counter ran during reset request");

    AST_NO_EARLY_REQ: assert property ( // R09
        !reset_req_o && count < limit - 19'h00001 && !(svc_done && win_mode && !window_now)
        |=> !reset_req_o
    ) else $error("reset request before timeout");

    AST_FAULT_STICKY: assert property ( // R10
        fault_cause |=> fault_cause
    ) else $error("fault cause dropped before reset");

    AST_FAULT_WIN_ONLY: assert property ( // R10
        !win_mode && !fault_cause |=> !fault_cause
    ) else $error("fault recorded outside windowed mode");

endmodule

`default_nettype wire

// ### verification/tb_wdt_top.sv
`include "wdt_consts.svh"
`default_nettype none

module tb_wdt_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] addr_i = 16'h0000;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic reset_req_o;
    logic window_open_o;
    logic rd_d = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] d;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0;
    int seed = 32'hb69b5ed8;

    wdt_top #(.LPO_DIV(4), .AW(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .reset_req_o(reset_req_o), .window_open_o(window_open_o));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        rd_d <= rd_i;
        if (rd_d) chk(rdata_o, exp_q.pop_front());
        if (cyc == 40000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask

    task automatic svc();
        wr(`WDT_SVC_OFS, 32'h55);
        wr(`WDT_SVC_OFS, 32'haa);
    endtask

    task automatic restart(input logic [31:0] ctrl);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(`WDT_CTRL_OFS, ctrl);
        t0 = cyc;
    endtask

    task automatic wait_req(input int lim);
        int n;
        n = 0;
        while (reset_req_o !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    initial begin
        // disabled with random upper bits: locked, reserved bits read zero
        d = $random(seed) & 32'hfffffff3;
        restart(d);
        rd(`WDT_CTRL_OFS, {28'h0, d[3:0]});
        wr(`WDT_CTRL_OFS, 32'h6);
        rd(`WDT_CTRL_OFS, {28'h0, d[3:0]});
        rd(16'h1200, 32'h0);
        rd(`WDT_SVC_OFS, 32'h0);
        for (int i = 0; i < 20; i++) wr(`WDT_SVC_OFS, $random(seed));
        repeat (9000) @(posedge clk_i);
        chk(reset_req_o, 1'b0);
        // slow clock, 32 ticks; window bit must have no effect
        restart(32'hfffffff5);
        rd(`WDT_CTRL_OFS, 32'h5);
        for (int i = 0; i < 3; i++) begin
            svc();
            repeat (96) @(posedge clk_i);
        end
        chk(reset_req_o, 1'b0);
        svc();
        t0 = cyc;
        wait_req(200);
        chk(((cyc - t0) >= 120 && (cyc - t0) <= 136), 1'b1);
        // bus clock, normal mode, broken key orders do not restart
        restart(32'h6);
        repeat (4000) @(posedge clk_i);
        wr(`WDT_SVC_OFS, 32'haa);
        wr(`WDT_SVC_OFS, 32'h55);
        wr(`WDT_SVC_OFS, 32'h12);
        wr(`WDT_SVC_OFS, 32'haa);
        wait_req(9000);
        chk(((cyc - t0) >= 8190 && (cyc - t0) <= 8197), 1'b1);
        rd(`WDT_STAT_OFS, 32'h12);
        // bus clock, windowed: window at three quarters, early service faults
        restart(32'h7);
        while (window_open_o !== 1'b1 && (cyc - t0) < 7000) @(posedge clk_i);
        chk(((cyc - t0) >= 6142 && (cyc - t0) <= 6149), 1'b1);
        svc();
        repeat (3) @(posedge clk_i);
        chk(window_open_o, 1'b0);
        chk(reset_req_o, 1'b0);
        svc();
        wait_req(4);
        chk(reset_req_o, 1'b1);
        rd(`WDT_STAT_OFS, 32'h16);
        repeat (2) @(posedge clk_i);
        report_and_stop();
    end
endmodule

`default_nettype wire
